// ==== hw/rtwbs_top.sv ====
// Two reload timers, the first also a serial baud-rate source.
`default_nettype none
module rtwbs_top
  import rtwbs_pkg::*;
(
  input wire logic mclk, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire rtwbs_sfr_t sfrBus, // Register address, write data, write strobe.
  output logic [7:0] sfrRdData, // Read data for last cycle's address.
  input wire logic firstClockDivideSelect, // First timer divide: 0 by 12.
  input wire logic firstIrqEnable, // First timer interrupt enable.
  input wire logic secondIrqEnable, // Second timer interrupt enable.
  input wire logic otherTimerOverflow, // Overflow pulse of the other timer.
  input wire logic externalCountPin, // Count pin, asynchronous.
  input wire logic externalTriggerPin, // Trigger pin, asynchronous.
  output logic rxShiftClock, // Receive shift-clock pulse.
  output logic txShiftClock, // Transmit shift-clock pulse.
  output logic rxBitTick, // Receive bit-rate pulse.
  output logic txBitTick, // Transmit bit-rate pulse.
  output logic firstIrq, // First timer interrupt request, level.
  output logic secondIrq // Second timer interrupt request, level.
);
  rtwbs_ctrl_t ctrl1_reg, ctrl1_next;
  logic [15:0] capture1_reg, capture1_next;
  logic [15:0] count1_reg, count1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] reloadLo2_reg, reloadLo2_next;
  logic [7:0] reloadHi2_reg, reloadHi2_next;
  logic [3:0] slowCnt_reg, slowCnt_next;
  logic half_reg, half_next;
  logic pinHalf_reg, pinHalf_next;
  logic [3:0] rxDiv_reg, rxDiv_next;
  logic [3:0] txDiv_reg, txDiv_next;
  logic rxShift_reg, rxShift_next;
  logic txShift_reg, txShift_next;
  logic rxTick_reg, rxTick_next;
  logic txTick_reg, txTick_next;
  logic irq1_reg, irq1_next;
  logic irq2_reg, irq2_next;
  logic [7:0] rdData_reg, rdData_next;
  logic countFall, triggerFall, slowTick, baudMode, reloadMode;
  logic internalStep, pinStep, step1, wrap1, trigger, step2, wrap2;
  logic [15:0] count2;

  function automatic logic wrHit(input rtwbs_sfr_t bus,
                                 input logic [7:0] addr);
    return bus.wrEn && (bus.addr == addr);
  endfunction

  function automatic logic [3:0] stepDiv(input logic [3:0] cnt,
                                         input logic pulse);
    return pulse ? cnt + 4'h1 : cnt;
  endfunction

  rtwbs_edge #(.STAGES(2)) countEdge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(externalCountPin),
    .fall(countFall)
  );

  rtwbs_edge #(.STAGES(2)) triggerEdge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(externalTriggerPin),
    .fall(triggerFall)
  );

  // The second timer has no pin input at all.
  rtwbs_reload16 #(.WIDTH(16)) secondTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .step(step2),
    .reloadValue({reloadHi2_reg, reloadLo2_reg}),
    .count(count2),
    .wrap(wrap2)
  );

  // Shared prescaler: one divide-by-twelve tick and a divide-by-two phase.
  always_comb
  begin
    slowTick = (slowCnt_reg == SLOW_LAST);
    slowCnt_next = slowTick ? 4'h0 : slowCnt_reg + 4'h1;
    half_next = !half_reg;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slowCnt_reg <= 4'h0;
      half_reg <= 1'b0;
    end
    else
    begin
      slowCnt_reg <= slowCnt_next;
      half_reg <= half_next;
    end
  end

  // First timer: count source, overflow, capture and reload.
  always_comb
  begin
    baudMode = ctrl1_reg.rxClockSelect || ctrl1_reg.txClockSelect;
    reloadMode = baudMode || !ctrl1_reg.captureReloadSelect;
    if (baudMode)
      internalStep = half_reg;
    else
      internalStep = firstClockDivideSelect || slowTick;
    // In baud mode every second pin edge counts, so the pin rate is
    // divided by 32 overall once the serial side divides by 16.
    pinHalf_next = pinHalf_reg;
    if (baudMode && ctrl1_reg.countSourceSelect && countFall)
      pinHalf_next = !pinHalf_reg;
    pinStep = countFall && (!baudMode || pinHalf_reg);
    step1 = ctrl1_reg.runControl &&
      (ctrl1_reg.countSourceSelect ? pinStep : internalStep);
    wrap1 = step1 && (count1_reg == COUNT_MAX);
    trigger = ctrl1_reg.externalTriggerEnable && triggerFall;

    count1_next = count1_reg;
    if (wrap1)
      count1_next = reloadMode ? capture1_reg : COUNT_ZERO;
    else if (step1)
      count1_next = count1_reg + 16'h0001;
    if (trigger && !baudMode && !ctrl1_reg.captureReloadSelect)
      count1_next = capture1_reg;
    if (wrHit(sfrBus, ADDR_FIRST_COUNT_LO))
      count1_next[7:0] = sfrBus.data;
    if (wrHit(sfrBus, ADDR_FIRST_COUNT_HI))
      count1_next[15:8] = sfrBus.data;

    capture1_next = capture1_reg;
    if (wrHit(sfrBus, ADDR_FIRST_CAPTURE_LO))
      capture1_next[7:0] = sfrBus.data;
    if (wrHit(sfrBus, ADDR_FIRST_CAPTURE_HI))
      capture1_next[15:8] = sfrBus.data;
    // A hardware capture beats a software write in the same cycle.
    if (trigger && !baudMode && ctrl1_reg.captureReloadSelect)
      capture1_next = count1_reg;

    ctrl1_next = ctrl1_reg;
    if (wrHit(sfrBus, ADDR_FIRST_CTRL))
      ctrl1_next = rtwbs_ctrl_t'(sfrBus.data);
    // Flags set by hardware win over a clearing write.
    if (wrap1 && !baudMode)
      ctrl1_next.overflowFlag = 1'b1;
    if (trigger)
      ctrl1_next.externalFlag = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_reg <= rtwbs_ctrl_t'(RESET_BYTE);
      capture1_reg <= COUNT_ZERO;
      count1_reg <= COUNT_ZERO;
      pinHalf_reg <= 1'b0;
    end
    else
    begin
      ctrl1_reg <= ctrl1_next;
      capture1_reg <= capture1_next;
      count1_reg <= count1_next;
      pinHalf_reg <= pinHalf_next;
    end
  end

  // Serial shift clocks and the divide-by-sixteen bit ticks.
  always_comb
  begin
    rxShift_next = ctrl1_reg.rxClockSelect ?
      (wrap1 && baudMode) : otherTimerOverflow;
    txShift_next = ctrl1_reg.txClockSelect ?
      (wrap1 && baudMode) : otherTimerOverflow;
    rxDiv_next = stepDiv(rxDiv_reg, rxShift_next);
    txDiv_next = stepDiv(txDiv_reg, txShift_next);
    rxTick_next = rxShift_next && (rxDiv_reg == BIT_LAST);
    txTick_next = txShift_next && (txDiv_reg == BIT_LAST);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxShift_reg <= 1'b0;
      txShift_reg <= 1'b0;
      rxDiv_reg <= 4'h0;
      txDiv_reg <= 4'h0;
      rxTick_reg <= 1'b0;
      txTick_reg <= 1'b0;
    end
    else
    begin
      rxShift_reg <= rxShift_next;
      txShift_reg <= txShift_next;
      rxDiv_reg <= rxDiv_next;
      txDiv_reg <= txDiv_next;
      rxTick_reg <= rxTick_next;
      txTick_reg <= txTick_next;
    end
  end

  // Second timer control and reload bytes.
  always_comb
  begin
    step2 = ctrl2_reg[SECOND_RUN_BIT] &&
      (ctrl2_reg[SECOND_DIV_BIT] || slowTick);
    ctrl2_next = ctrl2_reg;
    if (wrHit(sfrBus, ADDR_SECOND_CTRL))
      ctrl2_next = sfrBus.data & SECOND_CTRL_MASK;
    if (wrap2)
      ctrl2_next[SECOND_FLAG_BIT] = 1'b1;
    reloadLo2_next = reloadLo2_reg;
    if (wrHit(sfrBus, ADDR_SECOND_RELOAD_LO))
      reloadLo2_next = sfrBus.data;
    reloadHi2_next = reloadHi2_reg;
    if (wrHit(sfrBus, ADDR_SECOND_RELOAD_HI))
      reloadHi2_next = sfrBus.data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl2_reg <= RESET_BYTE;
      reloadLo2_reg <= RESET_BYTE;
      reloadHi2_reg <= RESET_BYTE;
    end
    else
    begin
      ctrl2_reg <= ctrl2_next;
      reloadLo2_reg <= reloadLo2_next;
      reloadHi2_reg <= reloadHi2_next;
    end
  end

  // Interrupt requests and register read-back.
  always_comb
  begin
    irq1_next = firstIrqEnable &&
      (ctrl1_reg.overflowFlag || ctrl1_reg.externalFlag);
    irq2_next = secondIrqEnable && ctrl2_reg[SECOND_FLAG_BIT];
    case (sfrBus.addr)
      ADDR_SECOND_CTRL: rdData_next = ctrl2_reg;
      ADDR_SECOND_RELOAD_LO: rdData_next = reloadLo2_reg;
      ADDR_SECOND_RELOAD_HI: rdData_next = reloadHi2_reg;
      ADDR_FIRST_CTRL: rdData_next = ctrl1_reg;
      ADDR_FIRST_CAPTURE_LO: rdData_next = capture1_reg[7:0];
      ADDR_FIRST_CAPTURE_HI: rdData_next = capture1_reg[15:8];
      ADDR_FIRST_COUNT_LO: rdData_next = count1_reg[7:0];
      ADDR_FIRST_COUNT_HI: rdData_next = count1_reg[15:8];
      default: rdData_next = RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq1_reg <= 1'b0;
      irq2_reg <= 1'b0;
      rdData_reg <= RESET_BYTE;
    end
    else
    begin
      irq1_reg <= irq1_next;
      irq2_reg <= irq2_next;
      rdData_reg <= rdData_next;
    end
  end

  assign sfrRdData = rdData_reg;
  assign rxShiftClock = rxShift_reg;
  assign txShiftClock = txShift_reg;
  assign rxBitTick = rxTick_reg;
  assign txBitTick = txTick_reg;
  assign firstIrq = irq1_reg;
  assign secondIrq = irq2_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence baudWrap;
    baudMode && wrap1 && !sfrBus.wrEn;
  endsequence

  baud_no_flag_a: assert property (
    baudWrap |=> !$rose(ctrl1_reg.overflowFlag))
    else $error("Overflow flag set in baud mode.");
  baud_reload_a: assert property (
    baudWrap ##0 ctrl1_reg.captureReloadSelect |=>
      count1_reg == $past(capture1_reg))
    else $error("Baud overflow did not reload.");
  rx_shift_a: assert property (
    baudWrap ##0 ctrl1_reg.rxClockSelect |=> rxShiftClock)
    else $error("Receive shift clock missing.");
  half_rate_a: assert property (
    baudMode && !ctrl1_reg.countSourceSelect && step1 |=> !step1)
    else $error("Baud internal step on adjacent cycles.");
  overflow_flag_a: assert property (
    !baudMode && wrap1 |=> ctrl1_reg.overflowFlag)
    else $error("Overflow flag not set.");
  ext_flag_a: assert property (trigger |=> ctrl1_reg.externalFlag)
    else $error("External flag not set.");
  first_irq_a: assert property (
    firstIrqEnable && ctrl1_reg.externalFlag |=> firstIrq)
    else $error("First interrupt not raised.");
  stopped_count_a: assert property (
    !ctrl1_reg.runControl && !sfrBus.wrEn && !trigger |=>
      $stable(count1_reg))
    else $error("Stopped timer changed.");
  capture_load_a: assert property (
    trigger && !baudMode && ctrl1_reg.captureReloadSelect |=>
      capture1_reg == $past(count1_reg))
    else $error("Capture did not take the count.");
  second_flag_a: assert property (wrap2 |=> ctrl2_reg[SECOND_FLAG_BIT])
    else $error("Second overflow flag not set.");
  unused_zero_a: assert property (
    (ctrl2_reg & ~SECOND_CTRL_MASK) == RESET_BYTE)
    else $error("Unused second-control bits not zero.");
endmodule
`default_nettype wire

// ==== hw/rtwbs_pkg.sv ====
// Package of register addresses, field layouts and constants for the timers.
`default_nettype none
package rtwbs_pkg;
  localparam logic [7:0] ADDR_SECOND_CTRL = 8'h91;
  localparam logic [7:0] ADDR_SECOND_RELOAD_LO = 8'h92;
  localparam logic [7:0] ADDR_SECOND_RELOAD_HI = 8'h93;
  localparam logic [7:0] ADDR_FIRST_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_FIRST_CAPTURE_LO = 8'hCA;
  localparam logic [7:0] ADDR_FIRST_CAPTURE_HI = 8'hCB;
  localparam logic [7:0] ADDR_FIRST_COUNT_LO = 8'hCC;
  localparam logic [7:0] ADDR_FIRST_COUNT_HI = 8'hCD;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [3:0] SLOW_LAST = 4'hB;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam int SECOND_FLAG_BIT = 7;
  localparam int SECOND_RUN_BIT = 2;
  localparam int SECOND_DIV_BIT = 1;
  localparam logic [7:0] SECOND_CTRL_MASK = 8'h86;

  typedef struct packed {
    logic overflowFlag;
    logic externalFlag;
    logic rxClockSelect;
    logic txClockSelect;
    logic externalTriggerEnable;
    logic runControl;
    logic countSourceSelect;
    logic captureReloadSelect;
  } rtwbs_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic wrEn;
  } rtwbs_sfr_t;
endpackage
`default_nettype wire

// ==== hw/rtwbs_edge.sv ====
// Pin synchroniser with a one-cycle falling-edge pulse.
`default_nettype none
module rtwbs_edge #(
  parameter int STAGES = 2
) (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic pin, // Raw pin from outside the clock domain.
  output logic fall // One-cycle pulse on a high-to-low transition.
);
  logic [STAGES-1:0] sync_reg;
  logic prev_reg;

  initial
  begin
    if (STAGES < 2)
      $error("rtwbs_edge needs at least two synchroniser stages.");
  end

  // Only the last stage feeds the edge compare, never the first.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg <= '1;
      prev_reg <= 1'b1;
    end
    else
    begin
      sync_reg <= {sync_reg[STAGES-2:0], pin};
      prev_reg <= sync_reg[STAGES-1];
    end
  end

  assign fall = prev_reg && !sync_reg[STAGES-1];
endmodule
`default_nettype wire

// ==== hw/rtwbs_reload16.sv ====
// Auto-reload up-counter used by the second timer.
`default_nettype none
module rtwbs_reload16
  import rtwbs_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic step, // Count enable for this cycle.
  input wire logic [WIDTH-1:0] reloadValue, // Value loaded on overflow.
  output logic [WIDTH-1:0] count, // Current count.
  output logic wrap // Pulse when the count rolls over.
);
  logic [WIDTH-1:0] count_reg, count_next;

  initial
  begin
    if (WIDTH != 16)
      $error("rtwbs_reload16 supports only a 16-bit count.");
  end

  always_comb
  begin
    wrap = step && (count_reg == COUNT_MAX);
    count_next = count_reg;
    if (wrap)
      count_next = reloadValue;
    else if (step)
      count_next = count_reg + 16'h0001;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= COUNT_ZERO;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;
endmodule
`default_nettype wire

// ==== test/rtwbs_uart_model.sv ====
// Serial-port side model: other-timer pulses and shift-clock measurements.
`default_nettype none
module rtwbs_uart_model #(
  parameter int OTHER_PERIOD = 7
) (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic rxShiftClock, // Receive shift pulse.
  input wire logic txShiftClock, // Transmit shift pulse.
  input wire logic rxBitTick, // Receive bit pulse.
  input wire logic txBitTick, // Transmit bit pulse.
  output logic otherTimerOverflow, // Other timer overflow pulse.
  output logic [7:0] rxGap, // Cycles between receive pulses.
  output logic [7:0] txGap, // Cycles between transmit pulses.
  output logic [7:0] rxPerBit, // Shift pulses per receive bit.
  output logic [7:0] txPerBit // Shift pulses per transmit bit.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div;
  logic [7:0] rxAge;
  logic [7:0] txAge;
  logic [7:0] rxSince;
  logic [7:0] txSince;

  // The other timer is a plain periodic pulse, so the gap is known exactly.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div <= 8'h00;
      otherTimerOverflow <= 1'b0;
      rxAge <= 8'h00;
      txAge <= 8'h00;
      rxGap <= 8'h00;
      txGap <= 8'h00;
      rxSince <= 8'h00;
      rxPerBit <= 8'h00;
      txSince <= 8'h00;
      txPerBit <= 8'h00;
    end
    else
    begin
      div <= (div == 8'(OTHER_PERIOD - 1)) ? 8'h00 : div + 8'h01;
      otherTimerOverflow <= (div == 8'h00);
      rxAge <= rxShiftClock ? 8'h00 : rxAge + 8'h01;
      txAge <= txShiftClock ? 8'h00 : txAge + 8'h01;
      if (rxShiftClock)
        rxGap <= rxAge + 8'h01;
      if (txShiftClock)
        txGap <= txAge + 8'h01;
      if (rxBitTick)
      begin
        rxPerBit <= rxSince + 8'h01;
        rxSince <= 8'h00;
      end
      else if (rxShiftClock)
        rxSince <= rxSince + 8'h01;
      if (txBitTick)
      begin
        txPerBit <= txSince + 8'h01;
        txSince <= 8'h00;
      end
      else if (txShiftClock)
        txSince <= txSince + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== test/rtwbs_top_tb.sv ====
// Self-checking bench for the two reload timers.
`default_nettype none
module rtwbs_top_tb
  import rtwbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 90000;
  logic mclk;
  logic rst_n;
  logic divSel;
  logic firstIrqEnable;
  logic secondIrqEnable;
  logic countPin;
  logic trigPin;
  rtwbs_sfr_t bus;
  logic [7:0] sfrRdData;
  logic [7:0] rxGap;
  logic [7:0] txGap;
  logic [7:0] rxPerBit;
  logic [7:0] txPerBit;
  logic txBitTick;
  logic rxShiftClock;
  logic txShiftClock;
  logic rxBitTick;
  logic firstIrq;
  logic secondIrq;
  logic otherOvf;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int g;
  logic [7:0] regs [8] = '{8'h91, 8'h92, 8'h93, 8'hC8, 8'hCA, 8'hCB,
    8'hCC, 8'hCD};

  rtwbs_top u_rtwbs_top (
    .mclk(mclk),
    .rst_n(rst_n),
    .sfrBus(bus),
    .sfrRdData(sfrRdData),
    .firstClockDivideSelect(divSel),
    .firstIrqEnable(firstIrqEnable),
    .secondIrqEnable(secondIrqEnable),
    .otherTimerOverflow(otherOvf),
    .externalCountPin(countPin),
    .externalTriggerPin(trigPin),
    .rxShiftClock(rxShiftClock),
    .txShiftClock(txShiftClock),
    .rxBitTick(rxBitTick),
    .txBitTick(txBitTick),
    .firstIrq(firstIrq),
    .secondIrq(secondIrq)
  );

  rtwbs_uart_model u_rtwbs_uart_model (
    .mclk(mclk),
    .rst_n(rst_n),
    .rxShiftClock(rxShiftClock),
    .txShiftClock(txShiftClock),
    .rxBitTick(rxBitTick),
    .txBitTick(txBitTick),
    .otherTimerOverflow(otherOvf),
    .rxGap(rxGap),
    .txGap(txGap),
    .rxPerBit(rxPerBit),
    .txPerBit(txPerBit)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The slowest path is the second timer's first wrap from a count near its reset value of zero.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus.addr = a;
    bus.data = d;
    bus.wrEn = 1'b1;
    @(negedge mclk);
    bus.wrEn = 1'b0;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    bus.addr = a;
    @(negedge mclk);
    chk({8'h00, sfrRdData}, {8'h00, e});
  endtask

  task automatic irqIs(input logic which, input logic lvl);
    chk({15'h0000, which ? secondIrq : firstIrq}, {15'h0000, lvl});
  endtask

  task automatic waitLvl(input logic which, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((which ? secondIrq : firstIrq) !== lvl && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    irqIs(which, lvl);
  endtask

  // The first gap may start from a stale flag, so only the last one counts.
  task automatic meas(input logic which, input logic [7:0] a,
    input logic [7:0] v, input int lim, output int gap);
    int t1;
    t1 = 0;
    gap = 0;
    for (int i = 0; i < 3; i++)
    begin
      waitLvl(which, 1'b1, lim);
      gap = cycles - t1;
      t1 = cycles;
      wr(a, v);
      waitLvl(which, 1'b0, 8);
    end
  endtask

  task automatic pinFall(input logic trig);
    @(negedge mclk);
    if (trig)
      trigPin = 1'b0;
    else
      countPin = 1'b0;
    repeat (6) @(negedge mclk);
    trigPin = 1'b1;
    countPin = 1'b1;
    repeat (6) @(negedge mclk);
  endtask

  task automatic done(input string s);
    $display("Test %s finished at %0t", s, $time);
  endtask

  initial
  begin
    bus = '0;
    divSel = 1'b1;
    firstIrqEnable = 1'b1;
    secondIrqEnable = 1'b1;
    countPin = 1'b1;
    trigPin = 1'b1;
    rst_n = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    foreach (regs[i])
      rd(regs[i], RESET_BYTE);
    foreach (regs[i])
      if (i != 0 && i != 3)
      begin
        wr(regs[i], 8'h5A);
        rd(regs[i], 8'h5A);
      end
    wr(8'h94, 8'hFF);
    rd(8'h94, RESET_BYTE);
    wr(ADDR_SECOND_CTRL, 8'hFF);
    rd(ADDR_SECOND_CTRL, 8'h86);
    wr(ADDR_SECOND_CTRL, 8'h79);
    rd(ADDR_SECOND_CTRL, 8'h00);
    done("registers");
    wr(ADDR_FIRST_CTRL, 8'h01);
    wr16(ADDR_FIRST_COUNT_LO, 16'h1234);
    pinFall(1'b1);
    rd(ADDR_FIRST_CAPTURE_LO, 8'h5A);
    rd(ADDR_FIRST_CTRL, 8'h01);
    wr(ADDR_FIRST_CTRL, 8'h09);
    pinFall(1'b1);
    rd(ADDR_FIRST_CAPTURE_LO, 8'h34);
    rd(ADDR_FIRST_CAPTURE_HI, 8'h12);
    rd(ADDR_FIRST_CTRL, 8'h49);
    irqIs(1'b0, 1'b1);
    firstIrqEnable = 1'b0;
    repeat (3) @(negedge mclk);
    irqIs(1'b0, 1'b0);
    firstIrqEnable = 1'b1;
    wr(ADDR_FIRST_CTRL, 8'h08);
    wr16(ADDR_FIRST_COUNT_LO, 16'h0000);
    pinFall(1'b1);
    rd(ADDR_FIRST_COUNT_LO, 8'h34);
    rd(ADDR_FIRST_COUNT_HI, 8'h12);
    rd(ADDR_FIRST_CTRL, 8'h48);
    wr(ADDR_FIRST_CTRL, 8'h00);
    repeat (3) @(negedge mclk);
    irqIs(1'b0, 1'b0);
    done("trigger");
    wr16(ADDR_FIRST_COUNT_LO, 16'h0000);
    wr(ADDR_FIRST_CTRL, 8'h06);
    repeat (3) pinFall(1'b0);
    wr(ADDR_FIRST_CTRL, 8'h00);
    pinFall(1'b0);
    rd(ADDR_FIRST_COUNT_LO, 8'h03);
    done("count pin");
    wr16(ADDR_FIRST_CAPTURE_LO, 16'hFFF0);
    wr16(ADDR_FIRST_COUNT_LO, 16'hFFF0);
    wr(ADDR_FIRST_CTRL, 8'h04);
    meas(1'b0, ADDR_FIRST_CTRL, 8'h04, 400, g);
    chk(16'(g), 16'h0010);
    divSel = 1'b0;
    meas(1'b0, ADDR_FIRST_CTRL, 8'h04, 400, g);
    chk(16'(g), 16'h00C0);
    wr(ADDR_FIRST_CTRL, 8'h00);
    done("first overflow");
    wr16(ADDR_SECOND_RELOAD_LO, 16'hFFF0);
    wr(ADDR_SECOND_CTRL, 8'h06);
    meas(1'b1, ADDR_SECOND_CTRL, 8'h06, 70000, g);
    chk(16'(g), 16'h0010);
    meas(1'b1, ADDR_SECOND_CTRL, 8'h04, 400, g);
    chk(16'(g), 16'h00C0);
    wr(ADDR_SECOND_CTRL, 8'h00);
    repeat (300) @(negedge mclk);
    irqIs(1'b1, 1'b0);
    done("second overflow");
    wr16(ADDR_FIRST_CAPTURE_LO, 16'hFFFE);
    wr16(ADDR_FIRST_COUNT_LO, 16'hFFFE);
    wr(ADDR_FIRST_CTRL, 8'h2D);
    repeat (200) @(negedge mclk);
    chk({8'h00, rxGap}, 16'h0004);
    chk({8'h00, rxPerBit}, 16'h0010);
    chk({8'h00, txGap}, 16'h0007);
    irqIs(1'b0, 1'b0);
    pinFall(1'b1);
    rd(ADDR_FIRST_CTRL, 8'h6D);
    irqIs(1'b0, 1'b1);
    wr(ADDR_FIRST_CTRL, 8'h14);
    repeat (200) @(negedge mclk);
    chk({8'h00, txGap}, 16'h0004);
    chk({8'h00, rxGap}, 16'h0007);
    rd(ADDR_FIRST_CTRL, 8'h14);
    chk({8'h00, txPerBit}, 16'h0010);
    // Pin-fed baud mode: the first edge after entry is swallowed.
    wr(ADDR_FIRST_CTRL, 8'h26);
    wr16(ADDR_FIRST_COUNT_LO, 16'hFFFE);
    repeat (2) pinFall(1'b0);
    rd(ADDR_FIRST_COUNT_LO, 8'hFF);
    repeat (2) pinFall(1'b0);
    rd(ADDR_FIRST_COUNT_LO, 8'hFE);
    rd(ADDR_FIRST_CTRL, 8'h26);
    wr(ADDR_FIRST_CTRL, 8'h00);
    done("baud");
    print_verdict();
  end
endmodule
`default_nettype wire
